// file: tisl_core.sv
// Terminal input start logic: decodes configured input functions into
// run, stop, direction, fault-clear and mode requests for the drive core.
// Assumes one core clock, field contacts on pins, permits as static levels.
//
// What this block does
// - Halt-and-fault-clear input open forces stop and not-ready; closed permits running.
// - Three-wire start assigned without halt-and-fault-clear input raises configuration alarm.
// - Rising halt-and-fault-clear clears faults when fault and terminal permits are set.
// - A dedicated clear-faults assignment disables fault clearing from the halt input.
// - Rising run-forward or run-reverse while stopped starts, unless halt input open.
// - Forward/reverse pair picks stop, reverse, forward or keep, with direction ownership.
// - An unassigned run-forward or run-reverse acts as permanently open.
// - Forward/reverse starts and direction changes need launch, heading, terminal permits.
// - Another direction owner blocks terminal run-direction starts and direction changes.
// - Run-forward or run-reverse assigned rejects other sources' start and jog requests.
// - Rising plain run while stopped starts in current direction unless halt open.
// - Plain run input open commands stop.
// - Run and start need launch and terminal permits; run assignment locks others.
// - Lockout holds while any run function assigned, even with configuration alarm.
// - Rising three-wire start while stopped starts in current direction unless halt open.
// - Run-permit open coasts the drive to stop and refuses starts.
// - Stop-method select open picks first method, closed picks second.
// - Ramp select chooses first or second acceleration and deceleration pair together.
// - Loop reset forces integrator to zero; hold freezes it.
// - Exclusive link input passes straight to a digital output, nothing else.
`include "tisl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tisl_core #(
	parameter int N = `TISL_N_INPUTS
) (
	input  wire logic                    core_clk,
	input  wire logic                    rstn,
	input  wire logic [N-1:0]            din_pin,
	input  wire logic [N*`TISL_SEL_W-1:0] din_func_sel,
	input  wire logic                    launch_permit_tb,
	input  wire logic                    heading_permit_tb,
	input  wire logic                    fault_permit_tb,
	input  wire logic                    terminal_permit_tb,
	input  wire logic                    dir_owned_by_other,
	input  wire logic                    drive_running,
	input  wire logic                    other_start_req,
	input  wire logic                    other_jog_req,
	output logic                         start_pulse,
	output logic                         halt_cmd,
	output logic                         coast_cmd,
	output logic                         not_ready,
	output logic                         fault_clear_pulse,
	output logic                         dir_reverse,
	output logic                         dir_owner_tb,
	output logic                         cfg_alarm,
	output logic                         others_locked,
	output logic                         other_start_ok,
	output logic                         other_jog_ok,
	output logic                         stop_method2,
	output logic                         ramp_set2,
	output logic                         pi_enable,
	output logic                         pi_integ_reset,
	output logic                         pi_integ_hold,
	output logic [N-1:0]                 excl_link_out
);

	localparam int W = `TISL_SEL_W;

	typedef struct packed {
		logic [N-1:0] prev;
		logic         start;
		logic         halt;
		logic         coast;
		logic         not_ready;
		logic         fclr;
		logic         dir_rev;
		logic         dir_own;
		logic         alarm;
		logic         lockout;
		logic         oth_start;
		logic         oth_jog;
		logic         mode2;
		logic         ramp2;
		logic         pi_en;
		logic         pi_rst;
		logic         pi_hold;
		logic [N-1:0] link;
	} tisl_core_state_t;

	tisl_core_state_t st_d;
	tisl_core_state_t st_q;
	logic [N-1:0]     lvl;

	tisl_sync #(.N(N)) u_sync (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.pin_raw   (din_pin),
		.pin_level (lvl)
	);

	// ------------------------------------------------------------------------
	// Function decode helpers
	// ------------------------------------------------------------------------
	function automatic logic [N-1:0] fn_map(input logic [N*W-1:0] sel,
	                                         input tisl_pkg::tisl_func_t code);
		logic [N-1:0] m;
		m = '0;
		for (int i = 0; i < N; i++) begin
			m[i] = (sel[i*W +: W] == code);
		end
		return m;
	endfunction : fn_map

	function automatic logic fn_closed(input logic [N*W-1:0] sel, input logic [N-1:0] v,
	                                   input tisl_pkg::tisl_func_t code);
		return |(fn_map(sel, code) & v);
	endfunction : fn_closed

	// ------------------------------------------------------------------------
	// Decoded levels and edges
	// ------------------------------------------------------------------------
	logic halt_asg, halt_lvl, halt_rise, halt_open;
	logic clrf_asg, clrf_rise;
	logic start_asg, start_rise;
	logic run_asg, run_lvl, run_rise;
	logic fwd_asg, fwd_lvl, fwd_rise, rev_asg, rev_lvl, rev_rise;
	logic ena_asg, ena_open;
	logic pair_asg, tb_ok, head_ok, lockout;
	logic [N-1:0] link_sel;

	always_comb begin
		halt_asg   = |fn_map(din_func_sel, tisl_pkg::tisl_fn_halt_clr);
		halt_lvl   = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_halt_clr);
		// Edge from current sample against last cycle's sample
		halt_rise  = halt_lvl & ~fn_closed(din_func_sel, st_q.prev, tisl_pkg::tisl_fn_halt_clr);
		halt_open  = halt_asg & ~halt_lvl;
		clrf_asg   = |fn_map(din_func_sel, tisl_pkg::tisl_fn_clr_faults);
		clrf_rise  = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_clr_faults)
		           & ~fn_closed(din_func_sel, st_q.prev, tisl_pkg::tisl_fn_clr_faults);
		start_asg  = |fn_map(din_func_sel, tisl_pkg::tisl_fn_start);
		start_rise = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_start)
		           & ~fn_closed(din_func_sel, st_q.prev, tisl_pkg::tisl_fn_start);
		run_asg    = |fn_map(din_func_sel, tisl_pkg::tisl_fn_run);
		run_lvl    = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_run);
		run_rise   = run_lvl & ~fn_closed(din_func_sel, st_q.prev, tisl_pkg::tisl_fn_run);
		// Unassigned half of the pair never closes
		fwd_asg    = |fn_map(din_func_sel, tisl_pkg::tisl_fn_run_fwd);
		fwd_lvl    = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_run_fwd);
		fwd_rise   = fwd_lvl & ~fn_closed(din_func_sel, st_q.prev, tisl_pkg::tisl_fn_run_fwd);
		rev_asg    = |fn_map(din_func_sel, tisl_pkg::tisl_fn_run_rev);
		rev_lvl    = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_run_rev);
		rev_rise   = rev_lvl & ~fn_closed(din_func_sel, st_q.prev, tisl_pkg::tisl_fn_run_rev);
		ena_asg    = |fn_map(din_func_sel, tisl_pkg::tisl_fn_enable);
		ena_open   = ena_asg & ~fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_enable);
		pair_asg   = fwd_asg | rev_asg;
		link_sel   = fn_map(din_func_sel, tisl_pkg::tisl_fn_excl_link);
		tb_ok      = launch_permit_tb & terminal_permit_tb;
		head_ok    = tb_ok & heading_permit_tb & ~dir_owned_by_other;
		lockout    = run_asg | pair_asg;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.prev = lvl;
		// Halt input open means stop and not ready
		st_d.not_ready = halt_open;
		st_d.halt      = halt_open
		               | (run_asg & ~run_lvl)
		               | (pair_asg & ~fwd_lvl & ~rev_lvl);
		st_d.coast     = ena_open;
		st_d.alarm     = start_asg & ~halt_asg;
		// Dedicated clear input takes fault clearing from the halt input
		st_d.fclr      = fault_permit_tb & terminal_permit_tb
		               & ((halt_rise & ~clrf_asg) | clrf_rise);
		st_d.start     = ~drive_running & ~halt_open & ~ena_open
		               & (((fwd_rise | rev_rise) & head_ok)
		               | (run_rise & tb_ok)
		               | (start_rise & tb_ok));
		// Direction ownership follows the pair
		if (!pair_asg || (!head_ok && !st_q.dir_own)
		    || !heading_permit_tb || !terminal_permit_tb) begin
			st_d.dir_own = 1'h0;
		end else if (!fwd_lvl && !rev_lvl) begin
			st_d.dir_own = 1'h0;
		end else if (!dir_owned_by_other) begin
			st_d.dir_own = 1'h1;
		end
		if (pair_asg && head_ok && (fwd_lvl ^ rev_lvl)) begin
			st_d.dir_rev = rev_lvl;
		end
		st_d.lockout   = lockout;
		st_d.oth_start = other_start_req & ~lockout & ~ena_open;
		st_d.oth_jog   = other_jog_req & ~lockout & ~ena_open;
		st_d.mode2     = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_stop_mode2);
		st_d.ramp2     = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_acc_dec2);
		st_d.pi_en     = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_pi_enable);
		st_d.pi_rst    = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_pi_reset);
		st_d.pi_hold   = fn_closed(din_func_sel, lvl, tisl_pkg::tisl_fn_pi_hold);
		st_d.link      = lvl & fn_map(din_func_sel, tisl_pkg::tisl_fn_excl_link);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q           <= '0;
			st_q.halt      <= `TISL_STOP_RST;
			st_q.not_ready <= `TISL_READY_RST;
			st_q.dir_rev   <= `TISL_DIR_RST;
			st_q.dir_own   <= `TISL_OWN_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign start_pulse       = st_q.start;
	assign halt_cmd          = st_q.halt;
	assign coast_cmd         = st_q.coast;
	assign not_ready         = st_q.not_ready;
	assign fault_clear_pulse = st_q.fclr;
	assign dir_reverse       = st_q.dir_rev;
	assign dir_owner_tb      = st_q.dir_own;
	assign cfg_alarm         = st_q.alarm;
	assign others_locked     = st_q.lockout;
	assign other_start_ok    = st_q.oth_start;
	assign other_jog_ok      = st_q.oth_jog;
	assign stop_method2      = st_q.mode2;
	assign ramp_set2         = st_q.ramp2;
	assign pi_enable         = st_q.pi_en;
	assign pi_integ_reset    = st_q.pi_rst;
	assign pi_integ_hold     = st_q.pi_hold;
	assign excl_link_out     = st_q.link;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_halt_open;
		@(posedge core_clk) disable iff (!rstn)
		halt_open |=> halt_cmd && not_ready && !start_pulse;
	endproperty
	a_halt_open: assert property (p_halt_open) else $error("halt open not honoured");

	property p_alarm;
		@(posedge core_clk) disable iff (!rstn)
		(start_asg && !halt_asg) |=> cfg_alarm;
	endproperty
	a_alarm: assert property (p_alarm) else $error("config alarm missing");

	property p_fclr_permit;
		@(posedge core_clk) disable iff (!rstn)
		fault_clear_pulse |-> $past(fault_permit_tb) && $past(terminal_permit_tb);
	endproperty
	a_fclr_permit: assert property (p_fclr_permit) else $error("clear without permit");

	property p_fclr_dedicated;
		@(posedge core_clk) disable iff (!rstn)
		(clrf_asg && !clrf_rise) |=> !fault_clear_pulse;
	endproperty
	a_fclr_dedicated: assert property (p_fclr_dedicated) else $error("halt edge cleared faults");

	property p_pair_start;
		@(posedge core_clk) disable iff (!rstn)
		(!drive_running && fwd_rise && head_ok && !halt_open && !ena_open) |=> start_pulse;
	endproperty
	a_pair_start: assert property (p_pair_start) else $error("pair edge did not start");

	property p_pair_open;
		@(posedge core_clk) disable iff (!rstn)
		(pair_asg && !fwd_lvl && !rev_lvl) |=> halt_cmd && !dir_owner_tb;
	endproperty
	a_pair_open: assert property (p_pair_open) else $error("pair open did not stop");

	property p_dir_other;
		@(posedge core_clk) disable iff (!rstn)
		dir_owned_by_other |=> $stable(dir_reverse);
	endproperty
	a_dir_other: assert property (p_dir_other) else $error("direction moved under other owner");

	property p_lockout;
		@(posedge core_clk) disable iff (!rstn)
		lockout |=> others_locked && !other_start_ok && !other_jog_ok;
	endproperty
	a_lockout: assert property (p_lockout) else $error("other source not locked out");

	property p_run_open;
		@(posedge core_clk) disable iff (!rstn)
		(run_asg && !run_lvl) |=> halt_cmd;
	endproperty
	a_run_open: assert property (p_run_open) else $error("run open did not stop");

	property p_coast;
		@(posedge core_clk) disable iff (!rstn)
		ena_open |=> coast_cmd && !start_pulse;
	endproperty
	a_coast: assert property (p_coast) else $error("permit open not coasting");

	property p_link;
		@(posedge core_clk) disable iff (!rstn)
		1'h1 |=> excl_link_out == ($past(lvl) & $past(link_sel));
	endproperty
	a_link: assert property (p_link) else $error("link output mismatch");

	c_start:  cover property (@(posedge core_clk) disable iff (!rstn) start_pulse);
	c_fclr:   cover property (@(posedge core_clk) disable iff (!rstn) fault_clear_pulse);
	c_alarm:  cover property (@(posedge core_clk) disable iff (!rstn) cfg_alarm);
	c_revrun: cover property (@(posedge core_clk) disable iff (!rstn) start_pulse && dir_reverse);

endmodule : tisl_core

`default_nettype wire

// file: tisl_defines.svh
// Constants of the terminal input start logic: widths, reset values,
// synchroniser depth. Included by bare name from every design file.
`ifndef TISL_DEFINES_SVH
`define TISL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define TISL_N_INPUTS   6
`define TISL_SEL_W      5
`define TISL_SYNC_DEPTH 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TISL_PIN_RST    1'h0
`define TISL_DIR_RST    1'h0
`define TISL_OWN_RST    1'h0
`define TISL_STOP_RST   1'h1
`define TISL_READY_RST  1'h1

`endif

// file: tisl_pkg.sv
// Types shared by the terminal input start logic.
// Assumes tisl_defines.svh is on the include path.
`include "tisl_defines.svh"
`default_nettype none

package tisl_pkg;

	// ------------------------------------------------------------------------
	// Input function codes
	// ------------------------------------------------------------------------
	typedef enum logic [`TISL_SEL_W-1:0] {
		tisl_fn_none       = 5'h00,
		tisl_fn_enable     = 5'h01,
		tisl_fn_clr_faults = 5'h02,
		tisl_fn_halt_clr   = 5'h04,
		tisl_fn_start      = 5'h05,
		tisl_fn_fwd_rev    = 5'h06,
		tisl_fn_run        = 5'h07,
		tisl_fn_run_fwd    = 5'h08,
		tisl_fn_run_rev    = 5'h09,
		tisl_fn_stop_mode2 = 5'h0d,
		tisl_fn_acc_dec2   = 5'h16,
		tisl_fn_excl_link  = 5'h1a,
		tisl_fn_pi_enable  = 5'h1b,
		tisl_fn_pi_reset   = 5'h1c,
		tisl_fn_pi_hold    = 5'h1d
	} tisl_func_t;

endpackage : tisl_pkg

`default_nettype wire

// file: tisl_sync.sv
// Three-stage synchroniser with agreement filter for the field contacts.
// Assumes asynchronous pins and one core clock.
`include "tisl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tisl_sync #(
	parameter int N = `TISL_N_INPUTS
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] pin_raw,
	output logic      [N-1:0] pin_level
);

	typedef struct packed {
		logic [N-1:0] ff1;
		logic [N-1:0] ff2;
		logic [N-1:0] ff3;
		logic [N-1:0] filt;
	} tisl_sync_state_t;

	tisl_sync_state_t st_d;
	tisl_sync_state_t st_q;

	// ------------------------------------------------------------------------
	// Level accepted once second and third stages agree
	// ------------------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.ff1  = pin_raw;
		st_d.ff2  = st_q.ff1;
		st_d.ff3  = st_q.ff2;
		st_d.filt = (st_q.ff3 & ~(st_q.ff2 ^ st_q.ff3)) | (st_q.filt & (st_q.ff2 ^ st_q.ff3));
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_level = st_q.filt;

endmodule : tisl_sync

`default_nettype wire

// file: tisl_field_model.sv
// Stand-in for the field contacts and the drive sequencing core.
// Assumes one core clock; contacts move only when the bench commands it.
`timescale 1ns/1ps
`default_nettype none

module tisl_field_model #(
	parameter int N = 6
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] contact_cmd,
	input  wire logic         start_pulse,
	input  wire logic         halt_cmd,
	input  wire logic         coast_cmd,
	output logic      [N-1:0] din_pin,
	output logic              drive_running
);
	// ------------------------------------------------------------------------
	// Contacts and run state
	// ------------------------------------------------------------------------
	assign din_pin = contact_cmd;

	// Start wins over a stop issued in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			drive_running <= 1'h0;
		end else if (start_pulse) begin
			drive_running <= 1'h1;
		end else if (halt_cmd || coast_cmd) begin
			drive_running <= 1'h0;
		end
	end
endmodule : tisl_field_model

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the terminal input start logic.
// Assumes tisl_pkg compiled first and the field model beside it.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        core_clk;
	logic        rstn;
	logic [29:0] din_func_sel;
	logic [5:0]  contact_cmd;
	logic [5:0]  din_pin;
	logic        launch_p, heading_p, fault_p, term_p;
	logic        dir_other, running, o_start, o_jog;
	logic        start_pulse, halt_cmd, coast_cmd, not_ready, fault_clear_pulse;
	logic        dir_reverse, dir_owner_tb, cfg_alarm, others_locked;
	logic        other_start_ok, other_jog_ok, stop_method2, ramp_set2;
	logic        pi_enable, pi_integ_reset, pi_integ_hold;
	logic [5:0]  excl_link_out;
	logic        sp, fc;
	int          err_total;
	int          tests_run;

	tisl_core #(.N(6)) uut (.core_clk(core_clk), .rstn(rstn), .din_pin(din_pin),
		.din_func_sel(din_func_sel), .launch_permit_tb(launch_p),
		.heading_permit_tb(heading_p), .fault_permit_tb(fault_p),
		.terminal_permit_tb(term_p), .dir_owned_by_other(dir_other),
		.drive_running(running), .other_start_req(o_start), .other_jog_req(o_jog),
		.start_pulse(start_pulse), .halt_cmd(halt_cmd), .coast_cmd(coast_cmd),
		.not_ready(not_ready), .fault_clear_pulse(fault_clear_pulse),
		.dir_reverse(dir_reverse), .dir_owner_tb(dir_owner_tb), .cfg_alarm(cfg_alarm),
		.others_locked(others_locked), .other_start_ok(other_start_ok),
		.other_jog_ok(other_jog_ok), .stop_method2(stop_method2), .ramp_set2(ramp_set2),
		.pi_enable(pi_enable), .pi_integ_reset(pi_integ_reset),
		.pi_integ_hold(pi_integ_hold), .excl_link_out(excl_link_out));

	tisl_field_model #(.N(6)) field (.core_clk(core_clk), .rstn(rstn),
		.contact_cmd(contact_cmd), .start_pulse(start_pulse), .halt_cmd(halt_cmd),
		.coast_cmd(coast_cmd), .din_pin(din_pin), .drive_running(running));

	// ------------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------------
	task automatic chk(input string nm, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic fn(input int i, input tisl_pkg::tisl_func_t c);
		din_func_sel[i*5 +: 5] = c;
		cyc(2);
	endtask : fn

	// Moves one contact and watches both pulses over the settling window
	task automatic pin(input int i, input logic v);
		contact_cmd[i] = v;
		sp = 1'h0;
		fc = 1'h0;
		repeat (8) begin
			@(posedge core_clk);
			#1;
			sp = sp | start_pulse;
			fc = fc | fault_clear_pulse;
		end
	endtask : pin

	task automatic complete_run;
		$display("TB: %0d checks, %0d errors", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------------------
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		#200000;
		err_total++;
		complete_run();
	end

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		err_total = 0;
		tests_run = 0;
		rstn = 1'h0;
		din_func_sel = '0;
		contact_cmd = '0;
		{launch_p, heading_p, fault_p, term_p} = 4'hf;
		{dir_other, o_start, o_jog} = 3'h3;
		cyc(10);
		chk("halt_cmd", halt_cmd, 1'h1);
		chk("not_ready", not_ready, 1'h1);
		rstn = 1'h1;
		cyc(8);
		chk("others_locked", others_locked, 1'h0);
		chk("other_start_ok", other_start_ok, 1'h1);
		chk("other_jog_ok", other_jog_ok, 1'h1);
		// Two-wire run with halt input
		fn(2, tisl_pkg::tisl_fn_enable);
		pin(2, 1'h1);
		fn(0, tisl_pkg::tisl_fn_halt_clr);
		fn(1, tisl_pkg::tisl_fn_run);
		chk("others_locked", others_locked, 1'h1);
		chk("other_start_ok", other_start_ok, 1'h0);
		chk("other_jog_ok", other_jog_ok, 1'h0);
		chk("not_ready", not_ready, 1'h1);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h0);
		pin(1, 1'h0);
		pin(0, 1'h1);
		chk("fault_clear_pulse", fc, 1'h1);
		chk("not_ready", not_ready, 1'h0);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h1);
		chk("halt_cmd", halt_cmd, 1'h0);
		pin(1, 1'h0);
		chk("halt_cmd", halt_cmd, 1'h1);
		pin(1, 1'h1);
		pin(2, 1'h0);
		chk("coast_cmd", coast_cmd, 1'h1);
		pin(1, 1'h0);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h0);
		pin(1, 1'h0);
		pin(2, 1'h1);
		launch_p = 1'h0;
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h0);
		pin(1, 1'h0);
		launch_p = 1'h1;
		pin(0, 1'h0);
		fault_p = 1'h0;
		pin(0, 1'h1);
		chk("fault_clear_pulse", fc, 1'h0);
		fault_p = 1'h1;
		fn(3, tisl_pkg::tisl_fn_clr_faults);
		pin(0, 1'h0);
		pin(0, 1'h1);
		chk("fault_clear_pulse", fc, 1'h0);
		// Level functions, two rounds of three
		for (int k = 0; k < 2; k++) begin
			fn(3, k ? tisl_pkg::tisl_fn_pi_enable : tisl_pkg::tisl_fn_stop_mode2);
			fn(4, k ? tisl_pkg::tisl_fn_pi_reset : tisl_pkg::tisl_fn_acc_dec2);
			fn(5, k ? tisl_pkg::tisl_fn_pi_hold : tisl_pkg::tisl_fn_excl_link);
			for (int v = 1; v >= 0; v--) begin
				pin(3, v[0]);
				pin(4, v[0]);
				pin(5, v[0]);
				chk("mode_a", k ? pi_enable : stop_method2, v[0]);
				chk("mode_b", k ? pi_integ_reset : ramp_set2, v[0]);
				chk("mode_c", k ? pi_integ_hold : excl_link_out[5], v[0]);
				chk("link_out", excl_link_out[5], k ? 1'h0 : v[0]);
				chk("start_pulse", sp, 1'h0);
			end
		end
		fn(3, tisl_pkg::tisl_fn_none);
		fn(4, tisl_pkg::tisl_fn_none);
		fn(5, tisl_pkg::tisl_fn_none);
		// Three-wire start
		fn(1, tisl_pkg::tisl_fn_start);
		chk("cfg_alarm", cfg_alarm, 1'h0);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h1);
		pin(1, 1'h0);
		pin(0, 1'h0);
		chk("halt_cmd", halt_cmd, 1'h1);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h0);
		pin(1, 1'h0);
		fn(0, tisl_pkg::tisl_fn_none);
		chk("cfg_alarm", cfg_alarm, 1'h1);
		fn(3, tisl_pkg::tisl_fn_run);
		chk("cfg_alarm", cfg_alarm, 1'h1);
		chk("others_locked", others_locked, 1'h1);
		fn(0, tisl_pkg::tisl_fn_halt_clr);
		pin(0, 1'h1);
		// Forward and reverse pair
		fn(1, tisl_pkg::tisl_fn_run_fwd);
		fn(3, tisl_pkg::tisl_fn_run_rev);
		chk("others_locked", others_locked, 1'h1);
		pin(3, 1'h1);
		chk("start_pulse", sp, 1'h1);
		chk("dir_reverse", dir_reverse, 1'h1);
		chk("dir_owner_tb", dir_owner_tb, 1'h1);
		pin(1, 1'h1);
		chk("dir_reverse", dir_reverse, 1'h1);
		chk("dir_owner_tb", dir_owner_tb, 1'h1);
		pin(3, 1'h0);
		chk("dir_reverse", dir_reverse, 1'h0);
		pin(1, 1'h0);
		chk("halt_cmd", halt_cmd, 1'h1);
		chk("dir_owner_tb", dir_owner_tb, 1'h0);
		dir_other = 1'h1;
		pin(3, 1'h1);
		chk("start_pulse", sp, 1'h0);
		chk("dir_reverse", dir_reverse, 1'h0);
		pin(3, 1'h0);
		dir_other = 1'h0;
		heading_p = 1'h0;
		pin(3, 1'h1);
		chk("start_pulse", sp, 1'h0);
		pin(3, 1'h0);
		heading_p = 1'h1;
		fn(3, tisl_pkg::tisl_fn_none);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h1);
		chk("dir_reverse", dir_reverse, 1'h0);
		pin(1, 1'h0);
		chk("halt_cmd", halt_cmd, 1'h1);
		pin(0, 1'h0);
		pin(1, 1'h1);
		chk("start_pulse", sp, 1'h0);
		pin(1, 1'h0);
		complete_run();
	end
endmodule : tb_top

`default_nettype wire
